// ==== logic/pgpc_pkg.sv ====
/*
  Package for the single-pin control block: register indices, control word
  layout, reset values, function codes and carrier structs.
  Assumes a 32-bit AXI4-Lite register bus where byte address = 4 * index.
*/
package pgpc_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam int          AXI_AW       = 18;
  localparam logic [15:0] CTRL_IDX     = 16'h403d;
  localparam logic [15:0] IRQ_STAT_IDX = 16'h4040;
  localparam logic [15:0] IRQ_CLR_IDX  = 16'h4041;
  localparam logic [15:0] IRQ_EN_IDX   = 16'h4042;
  localparam logic [15:0] DATA_IDX     = 16'h4043;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  // ----------------------------------------------------------------------
  // Control word
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic       pin_direction;        // 15: 1 input, 0 output
    logic [1:0] pull_select;          // 14:13
    logic       irq_edge_mode;        // 12
    logic       supply_domain_select; // 11
    logic       pin_polarity;         // 10
    logic       open_drain_select;    // 9
    logic       rsv8;                 // 8
    logic       pin_enable;           // 7
    logic [2:0] rsv6_4;               // 6:4
    logic [3:0] pin_function;         // 3:0
  } pgpc_ctrl_s;

  localparam logic [15:0] CTRL_RST  = 16'ha400;
  localparam logic [15:0] CTRL_MASK = 16'hfe8f;

  localparam logic [1:0] PULL_NONE = 2'h0;
  localparam logic [1:0] PULL_DOWN = 2'h1;
  localparam logic [1:0] PULL_UP   = 2'h2;

  // ----------------------------------------------------------------------
  // Function codes
  // ----------------------------------------------------------------------
  localparam logic [3:0] FN_IN_GPIO_LONG  = 4'h0;
  localparam logic [3:0] FN_IN_GPIO       = 4'h1;
  localparam logic [3:0] FN_IN_PWR_ONOFF  = 4'h2;
  localparam logic [3:0] FN_IN_SLP_WAKE   = 4'h3;
  localparam logic [3:0] FN_IN_SLP_WAKE_L = 4'h4;
  localparam logic [3:0] FN_IN_SLEEP      = 4'h5;
  localparam logic [3:0] FN_IN_PWR_ON     = 4'h6;
  localparam logic [3:0] FN_IN_WDOG       = 4'h7;
  localparam logic [3:0] FN_IN_VSEL1      = 4'h8;
  localparam logic [3:0] FN_IN_VSEL2      = 4'h9;
  localparam logic [3:0] FN_IN_HWEN1      = 4'ha;
  localparam logic [3:0] FN_IN_HWEN2      = 4'hb;
  localparam logic [3:0] FN_IN_HWCTL1     = 4'hc;
  localparam logic [3:0] FN_IN_HWCTL2     = 4'hd;
  localparam logic [3:0] FN_IN_HWCTL1_L   = 4'he;
  localparam logic [3:0] FN_IN_HWCTL2_L   = 4'hf;

  localparam logic [3:0] FN_OUT_GPIO      = 4'h0;
  localparam logic [3:0] FN_OUT_OSC32K    = 4'h1;
  localparam logic [3:0] FN_OUT_ON_ST     = 4'h2;
  localparam logic [3:0] FN_OUT_SLEEP_ST  = 4'h3;
  localparam logic [3:0] FN_OUT_ST_CHG    = 4'h4;
  localparam logic [3:0] FN_OUT_VS1_DONE  = 4'h8;
  localparam logic [3:0] FN_OUT_VS2_DONE  = 4'h9;
  localparam logic [3:0] FN_OUT_EXT_EN1   = 4'ha;
  localparam logic [3:0] FN_OUT_EXT_EN2   = 4'hb;
  localparam logic [3:0] FN_OUT_SYS_GOOD  = 4'hc;
  localparam logic [3:0] FN_OUT_CONV_GOOD = 4'hd;
  localparam logic [3:0] FN_OUT_PWR_CLK   = 4'he;
  localparam logic [3:0] FN_OUT_AUX_RST   = 4'hf;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_HZ         = 100_000_000;
  localparam int PWR_CLK_HZ     = 2_000_000;
  localparam int PWR_CLK_HALF   = CLK_HZ / (2 * PWR_CLK_HZ);
  localparam int DB_SHORT_DEF   = 16;
  localparam int DB_LONG_DEF    = 1000;

  // ----------------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic       osc_32k;
    logic       on_state;
    logic       sleep_state;
    logic       state_change;
    logic [1:0] dvs_done;
    logic [1:0] ext_power_enable;
    logic       system_supply_good;
    logic       converters_power_good;
    logic       aux_reset;
  } pgpc_out_src_s;

  typedef struct packed {
    logic       gpio_level;
    logic       power_onoff_req;
    logic       sleep_wake_req;
    logic       sleep_req;
    logic       power_on_req;
    logic       watchdog_reset;
    logic       voltage_scaling_select_1;
    logic       voltage_scaling_select_2;
    logic [1:0] hw_enable_req;
    logic [1:0] hw_control;
  } pgpc_in_role_s;

endpackage

// ==== logic/pgpc_pin_ctrl.sv ====
/*
  Control, function select, debounce and interrupt logic for one
  general-purpose pin, with an AXI4-Lite register slave.
  Assumes pad and source inputs are synchronous to clk; the pad wire
  itself is resolved outside from pad_out and pad_oe.
*/
`timescale 1ns/1ps
module pgpc_pin_ctrl
  import pgpc_pkg::*;
#(
  parameter int DB_SHORT_CYC = DB_SHORT_DEF,
  parameter int DB_LONG_CYC  = DB_LONG_DEF
) (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                sys_rst,
  // AXI4-Lite write address
  input  wire logic [AXI_AW-1:0]   s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [AXI_AW-1:0]   s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  // Pad
  input  wire logic                pad_in,
  output logic                     pad_out,
  output logic                     pad_oe,
  output logic                     pull_up_en,
  output logic                     pull_down_en,
  output logic                     supply_domain_select,
  // Output function sources
  input  wire pgpc_out_src_s       out_src,
  // Input function roles
  output pgpc_in_role_s            in_role,
  // Interrupt
  output logic                     irq
);

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  pgpc_ctrl_s         ctrl_r;
  logic               sw_level_r;
  logic               irq_stat_r;
  logic               irq_en_r;
  logic               db_level_r;
  logic               db_prev_r;
  logic [15:0]        db_cnt_r;
  logic [7:0]         pclk_cnt_r;
  logic               pclk_r;

  logic [AXI_AW-1:0]  aw_addr_r;
  logic               aw_held_r;
  logic [31:0]        w_data_r;
  logic [3:0]         w_strb_r;
  logic               w_held_r;

  // ----------------------------------------------------------------------
  // AXI4-Lite write path
  // ----------------------------------------------------------------------
  logic               wr_fire;
  logic [15:0]        wr_idx;
  logic               wr_ok;

  assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_r && !s_axi_bvalid;
  assign wr_fire       = aw_held_r && w_held_r && !s_axi_bvalid;
  assign wr_idx        = 16'(aw_addr_r >> 2);
  assign wr_ok         = (wr_idx == CTRL_IDX) || (wr_idx == IRQ_STAT_IDX) ||
                         (wr_idx == IRQ_CLR_IDX) || (wr_idx == IRQ_EN_IDX) ||
                         (wr_idx == DATA_IDX);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      aw_held_r <= 1'b0;
      aw_addr_r <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_r <= 1'b1;
      aw_addr_r <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held_r <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      w_held_r <= 1'b0;
      w_data_r <= '0;
      w_strb_r <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_r <= 1'b1;
      w_data_r <= s_axi_wdata;
      w_strb_r <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held_r <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Control and data registers
  // ----------------------------------------------------------------------
  logic [15:0] ctrl_nxt;

  always_comb begin
    ctrl_nxt = ctrl_r;
    if (w_strb_r[0]) begin
      ctrl_nxt[7:0] = w_data_r[7:0];
    end
    if (w_strb_r[1]) begin
      ctrl_nxt[15:8] = w_data_r[15:8];
    end
    ctrl_nxt = ctrl_nxt & CTRL_MASK;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl_r <= CTRL_RST;
    end else if (wr_fire && wr_idx == CTRL_IDX) begin
      ctrl_r <= ctrl_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sw_level_r <= 1'b0;
      irq_en_r   <= 1'b0;
    end else if (wr_fire && w_strb_r[0]) begin
      if (wr_idx == DATA_IDX) begin
        sw_level_r <= w_data_r[0];
      end
      if (wr_idx == IRQ_EN_IDX) begin
        irq_en_r <= w_data_r[0];
      end
    end
  end

  // ----------------------------------------------------------------------
  // AXI4-Lite read path
  // ----------------------------------------------------------------------
  logic [15:0] rd_idx;

  assign s_axi_arready = !s_axi_rvalid;
  assign rd_idx        = 16'(s_axi_araddr >> 2);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= RESP_OKAY;
      s_axi_rdata  <= '0;
      if (rd_idx == CTRL_IDX) begin
        s_axi_rdata <= {16'h0000, ctrl_r};
      end else if (rd_idx == IRQ_STAT_IDX) begin
        s_axi_rdata <= {31'h0, irq_stat_r};
      end else if (rd_idx == IRQ_CLR_IDX) begin
        s_axi_rdata <= '0;
      end else if (rd_idx == IRQ_EN_IDX) begin
        s_axi_rdata <= {31'h0, irq_en_r};
      end else if (rd_idx == DATA_IDX) begin
        s_axi_rdata <= {30'h0, db_level_r, sw_level_r};
      end else begin
        s_axi_rresp <= RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Input debounce
  // ----------------------------------------------------------------------
  logic        long_db;
  logic [15:0] db_limit;
  logic        pin_logic;

  assign pin_logic = pad_in ^ ~ctrl_r.pin_polarity;
  assign long_db   = (ctrl_r.pin_function == FN_IN_GPIO_LONG) ||
                     (ctrl_r.pin_function == FN_IN_SLP_WAKE_L) ||
                     (ctrl_r.pin_function == FN_IN_HWCTL1_L) ||
                     (ctrl_r.pin_function == FN_IN_HWCTL2_L);
  assign db_limit  = long_db ? 16'(DB_LONG_CYC) : 16'(DB_SHORT_CYC);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      db_cnt_r   <= '0;
      db_level_r <= 1'b0;
    end else if (pin_logic == db_level_r) begin
      db_cnt_r <= '0;
    end else if (db_cnt_r + 16'h0001 >= db_limit) begin
      db_cnt_r   <= '0;
      db_level_r <= pin_logic;
    end else begin
      db_cnt_r <= db_cnt_r + 16'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      db_prev_r <= 1'b0;
    end else begin
      db_prev_r <= db_level_r;
    end
  end

  // ----------------------------------------------------------------------
  // Pin interrupt
  // ----------------------------------------------------------------------
  logic in_active;
  logic edge_evt;

  assign in_active = ctrl_r.pin_direction && ctrl_r.pin_enable;
  always_comb begin
    if (ctrl_r.irq_edge_mode) begin
      edge_evt = db_level_r != db_prev_r;
    end else begin
      edge_evt = db_level_r && !db_prev_r;
    end
    edge_evt = edge_evt && in_active;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_stat_r <= 1'b0;
    end else if (edge_evt) begin
      irq_stat_r <= 1'b1;
    end else if (wr_fire && wr_idx == IRQ_CLR_IDX && w_strb_r[0] && w_data_r[0]) begin
      irq_stat_r <= 1'b0;
    end
  end

  assign irq = irq_stat_r && irq_en_r;

  // ----------------------------------------------------------------------
  // Input roles
  // ----------------------------------------------------------------------
  logic [3:0] fn;
  logic       lvl;

  assign fn  = ctrl_r.pin_function;
  assign lvl = db_level_r && in_active;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      in_role <= '0;
    end else begin
      in_role.gpio_level               <= lvl && (fn == FN_IN_GPIO_LONG ||
                                                  fn == FN_IN_GPIO);
      in_role.power_onoff_req          <= lvl && fn == FN_IN_PWR_ONOFF;
      in_role.sleep_wake_req           <= lvl && (fn == FN_IN_SLP_WAKE ||
                                                  fn == FN_IN_SLP_WAKE_L);
      in_role.sleep_req                <= lvl && fn == FN_IN_SLEEP;
      in_role.power_on_req             <= lvl && fn == FN_IN_PWR_ON;
      in_role.watchdog_reset           <= lvl && fn == FN_IN_WDOG;
      in_role.voltage_scaling_select_1 <= lvl && fn == FN_IN_VSEL1;
      in_role.voltage_scaling_select_2 <= lvl && fn == FN_IN_VSEL2;
      in_role.hw_enable_req[0]         <= lvl && fn == FN_IN_HWEN1;
      in_role.hw_enable_req[1]         <= lvl && fn == FN_IN_HWEN2;
      in_role.hw_control[0]            <= lvl && (fn == FN_IN_HWCTL1 ||
                                                  fn == FN_IN_HWCTL1_L);
      in_role.hw_control[1]            <= lvl && (fn == FN_IN_HWCTL2 ||
                                                  fn == FN_IN_HWCTL2_L);
    end
  end

  // ----------------------------------------------------------------------
  // Power clock divider
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pclk_cnt_r <= '0;
      pclk_r     <= 1'b0;
    end else if (pclk_cnt_r == 8'(PWR_CLK_HALF - 1)) begin
      pclk_cnt_r <= '0;
      pclk_r     <= !pclk_r;
    end else begin
      pclk_cnt_r <= pclk_cnt_r + 8'h01;
    end
  end

  // ----------------------------------------------------------------------
  // Output function select and driver
  // ----------------------------------------------------------------------
  logic out_src_lvl;
  logic out_lvl;
  logic drive_on;

  always_comb begin
    unique case (fn)
      FN_OUT_GPIO:      out_src_lvl = sw_level_r;
      FN_OUT_OSC32K:    out_src_lvl = out_src.osc_32k;
      FN_OUT_ON_ST:     out_src_lvl = out_src.on_state;
      FN_OUT_SLEEP_ST:  out_src_lvl = out_src.sleep_state;
      FN_OUT_ST_CHG:    out_src_lvl = out_src.state_change;
      FN_OUT_VS1_DONE:  out_src_lvl = out_src.dvs_done[0];
      FN_OUT_VS2_DONE:  out_src_lvl = out_src.dvs_done[1];
      FN_OUT_EXT_EN1:   out_src_lvl = out_src.ext_power_enable[0];
      FN_OUT_EXT_EN2:   out_src_lvl = out_src.ext_power_enable[1];
      FN_OUT_SYS_GOOD:  out_src_lvl = out_src.system_supply_good;
      FN_OUT_CONV_GOOD: out_src_lvl = out_src.converters_power_good;
      FN_OUT_PWR_CLK:   out_src_lvl = pclk_r;
      FN_OUT_AUX_RST:   out_src_lvl = out_src.aux_reset;
      default:          out_src_lvl = 1'b0;
    endcase
  end

  // Reserved codes drive a plain low whatever the polarity
  assign out_lvl  = (fn == 4'h5 || fn == 4'h6 || fn == 4'h7) ? 1'b0 :
                    out_src_lvl ^ ~ctrl_r.pin_polarity;
  assign drive_on = !ctrl_r.pin_direction && ctrl_r.pin_enable;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pad_out <= 1'b0;
      pad_oe  <= 1'b0;
    end else if (!drive_on) begin
      pad_out <= 1'b0;
      pad_oe  <= 1'b0;
    end else if (ctrl_r.open_drain_select) begin
      pad_out <= 1'b0;
      pad_oe  <= !out_lvl;
    end else begin
      pad_out <= out_lvl;
      pad_oe  <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Pull and supply selects
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pull_up_en           <= 1'b0;
      pull_down_en         <= 1'b1;
      supply_domain_select <= 1'b0;
    end else begin
      pull_up_en           <= ctrl_r.pull_select == PULL_UP;
      pull_down_en         <= ctrl_r.pull_select == PULL_DOWN;
      supply_domain_select <= ctrl_r.supply_domain_select;
    end
  end

endmodule

// ==== tb/pgpc_pin_model.sv ====
/*
  Far side of the pin: system logic and the wire itself.
  Assumes the block's pad outputs; ext_en and ext_lvl come from the bench.
*/
`timescale 1ns/1ps
module pgpc_pin_model (
  // Clock
  input  wire logic clk,
  // Block pad side
  input  wire logic pad_out,
  input  wire logic pad_oe,
  input  wire logic pull_up_en,
  input  wire logic pull_down_en,
  // Far driver
  input  wire logic ext_en,
  input  wire logic ext_lvl,
  output logic      pad_in
);
  // ----------------------------------------------------------------------
  // Wire level, sampled on clk
  // ----------------------------------------------------------------------
  logic lvl_r;
  always_ff @(posedge clk) begin
    if (pad_oe)
      lvl_r <= pad_out;
    else if (ext_en)
      lvl_r <= ext_lvl;
    else if (pull_up_en)
      lvl_r <= 1'b1;
    else if (pull_down_en)
      lvl_r <= 1'b0;
    else
      lvl_r <= !lvl_r;
  end
  assign pad_in = lvl_r;
endmodule

// ==== tb/pgpc_pin_ctrl_chk.sv ====
/*
  Checker: pad outputs against a shadow of the control word.
  Assumes write address and data are offered together.
*/
`timescale 1ns/1ps
module pgpc_pin_ctrl_chk
  import pgpc_pkg::*;
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              sys_rst,
  // Write channels
  input  wire logic [AXI_AW-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  input  wire logic              s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic              s_axi_wvalid,
  input  wire logic              s_axi_wready,
  // Pad and interrupt
  input  wire logic              pad_out,
  input  wire logic              pad_oe,
  input  wire logic              pull_up_en,
  input  wire logic              pull_down_en,
  input  wire logic              supply_domain_select,
  input  wire logic              irq
);
  pgpc_ctrl_s sh_r;
  always_ff @(posedge clk) begin
    if (sys_rst)
      sh_r <= CTRL_RST;
    else if (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
             && s_axi_awaddr == {CTRL_IDX, 2'h0})
      sh_r <= s_axi_wdata[15:0] & CTRL_MASK;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_settled;
    sh_r == $past(sh_r) && sh_r == $past(sh_r, 2);
  endsequence
  sequence s_drive;
    s_settled ##0 sh_r.pin_enable && !sh_r.pin_direction;
  endsequence
  a_reset_idle:
    assert property ($fell(sys_rst) |->
      !pad_oe && pull_down_en && !pull_up_en && !supply_domain_select && !irq)
    else $error("pin not idle after reset");
  a_pull_follow:
    assert property (s_settled |-> pull_up_en == (sh_r.pull_select == PULL_UP)
      && pull_down_en == (sh_r.pull_select == PULL_DOWN))
    else $error("pull select wrong");
  a_pull_exclusive:
    assert property (!(pull_up_en && pull_down_en))
    else $error("both pulls on");
  a_supply_follow:
    assert property (s_settled |-> supply_domain_select == sh_r.supply_domain_select)
    else $error("supply select wrong");
  a_tristate_off:
    assert property (s_settled ##0 !sh_r.pin_enable |-> !pad_oe)
    else $error("disabled pin driven");
  a_input_release:
    assert property (s_settled ##0 sh_r.pin_direction |-> !pad_oe)
    else $error("input pin driven");
  a_push_pull:
    assert property (s_drive ##0 !sh_r.open_drain_select |-> pad_oe)
    else $error("push-pull not driving");
  a_open_drain:
    assert property (s_drive ##0 sh_r.open_drain_select |-> !pad_out)
    else $error("open drain drives high");
  a_reserved_low:
    assert property (s_drive ##0 sh_r.pin_function inside {[4'h5:4'h7]} |-> !pad_out)
    else $error("reserved code not low");
endmodule

bind pgpc_pin_ctrl pgpc_pin_ctrl_chk u_chk (.clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .pad_out, .pad_oe,
  .pull_up_en, .pull_down_en, .supply_domain_select, .irq);

// ==== tb/pgpc_pin_ctrl_bench.sv ====
/*
  Bench: AXI4-Lite tasks, output and input function sweeps, interrupts.
  Assumes debounce limits of 2 and 12 cycles and the far-side pin model.
*/
`timescale 1ns/1ps
module pgpc_pin_ctrl_bench
  import pgpc_pkg::*;
;
  logic              clk, sys_rst, pad_in, pad_out, pad_oe, pull_up_en, pull_down_en, irq;
  logic              supply_domain_select, ext_en, ext_lvl, s_axi_awvalid, s_axi_awready;
  logic              s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic              s_axi_arready, s_axi_rvalid, s_axi_rready, p;
  logic [AXI_AW-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0]       s_axi_wdata, s_axi_rdata;
  logic [3:0]        s_axi_wstrb;
  logic [1:0]        s_axi_bresp, s_axi_rresp;
  pgpc_out_src_s     out_src;
  pgpc_in_role_s     in_role;
  int                fails, n_checks, cyc, n;
  localparam logic [1:0] OK = RESP_OKAY;
  localparam int OBIT [16] = '{-1, 10, 9, 8, 7, -1, -1, -1, 5, 6, 3, 4, 2, 1, -1, 0};
  localparam int IBIT [16] = '{11, 11, 10, 9, 9, 8, 7, 6, 5, 4, 2, 3, 0, 1, 0, 1};

  pgpc_pin_ctrl #(.DB_SHORT_CYC(2), .DB_LONG_CYC(12)) dut (.*);
  pgpc_pin_model u_far (.*);

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      fails++;
      end_sim;
    end
  end
  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [15:0] idx, input logic [31:0] d, input logic [1:0] er);
    @(posedge clk);
    s_axi_awaddr <= {idx, 2'h0};
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, er);
    repeat (2) @(posedge clk);
  endtask
  task automatic rd(input logic [15:0] idx, input logic [31:0] ed, input logic [1:0] er);
    @(posedge clk);
    s_axi_araddr <= {idx, 2'h0};
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk(s_axi_rresp, er);
    if (er == OK) chk(s_axi_rdata, ed);
  endtask
  task automatic pin(input logic l, input int c);
    ext_lvl <= l;
    repeat (c) @(posedge clk);
  endtask
  task automatic ev(input logic l, input logic e);
    pin(l, 20);
    chk(irq, e);
    wr(IRQ_CLR_IDX, 1, OK);
    chk(irq, 0);
  endtask
  // ----------------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------------
  initial begin
    sys_rst = 1'b1;
    {ext_en, ext_lvl, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    out_src = '0;
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    rd(CTRL_IDX, 32'(CTRL_RST), OK);
    chk({pad_oe, pull_up_en, pull_down_en, supply_domain_select}, 4'h2);
    rd(16'h4050, 0, RESP_SLVERR);
    wr(CTRL_IDX, 32'hffff, OK);
    rd(CTRL_IDX, 32'(CTRL_MASK), OK);
    chk({pull_up_en, pull_down_en}, 0);
    wr(CTRL_IDX, 32'h4000, OK);
    chk({pull_up_en, pull_down_en}, 2'h2);
    wr(DATA_IDX, 1, OK);
    for (int k = 0; k < 16; k++) begin
      wr(CTRL_IDX, 32'h0c80 | k, OK);
      out_src <= (OBIT[k] < 0) ? '1 : 11'(1) << OBIT[k];
      repeat (4) @(posedge clk);
      if (k == 14) begin
        n = 0;
        repeat (100) begin
          p = pad_out;
          @(posedge clk);
          n += int'(pad_out != p);
        end
        chk(n, 4);
      end else
        chk({pad_oe, pad_out, supply_domain_select},
            {2'h2 | !(k inside {[5:7]}), 1'b1});
      if (OBIT[k] >= 0) begin
        out_src <= ~(11'(1) << OBIT[k]);
        repeat (4) @(posedge clk);
        chk(pad_out, 0);
      end
    end
    out_src <= 11'h004;
    wr(CTRL_IDX, 32'h088c, OK);
    chk(pad_out, 0);
    wr(CTRL_IDX, 32'h0e8c, OK);
    chk({pad_oe, pad_out}, 0);
    out_src <= '0;
    repeat (4) @(posedge clk);
    chk({pad_oe, pad_out}, 2'h2);
    wr(CTRL_IDX, 32'h0c0c, OK);
    chk(pad_oe, 0);
    ext_en <= 1'b1;
    for (int k = 0; k < 16; k++) begin
      wr(CTRL_IDX, 32'h8480 | k, OK);
      pin(1'b1, 8);
      chk(in_role, (k inside {0, 4, 14, 15}) ? 0 : 12'(1) << IBIT[k]);
      pin(1'b1, 12);
      chk(in_role, 12'(1) << IBIT[k]);
      pin(1'b0, 20);
      chk(in_role, 0);
    end
    wr(CTRL_IDX, 32'h8481, OK);
    wr(IRQ_EN_IDX, 1, OK);
    wr(IRQ_CLR_IDX, 1, OK);
    ev(1'b1, 1'b1);
    ev(1'b0, 1'b0);
    wr(CTRL_IDX, 32'h8081, OK);
    ev(1'b0, 1'b1);
    ev(1'b1, 1'b0);
    ev(1'b0, 1'b1);
    wr(CTRL_IDX, 32'h9481, OK);
    ev(1'b0, 1'b1);
    ev(1'b1, 1'b1);
    ev(1'b0, 1'b1);
    wr(IRQ_EN_IDX, 0, OK);
    pin(1'b1, 20);
    chk(irq, 0);
    rd(DATA_IDX, 32'h3, OK);
    rd(IRQ_STAT_IDX, 1, OK);
    rd(IRQ_CLR_IDX, 0, OK);
    wr(IRQ_CLR_IDX, 1, OK);
    rd(IRQ_STAT_IDX, 0, OK);
    end_sim;
  end
endmodule
